// ==== src/pls_defines.svh ====
// timing-free constants for the logic slice: widths, table sizes, init and reset values
`ifndef PLS_DEFINES_SVH
`define PLS_DEFINES_SVH
`define PLS_TABLE_INPUTS   4
`define PLS_TABLE_ENTRIES  16
`define PLS_TABLE_INIT     16'h0000
`define PLS_COUNT_WIDTH    2
`define PLS_COUNT_RESET    2'h0
`define PLS_MODE_WIDTH     2
`endif

// ==== src/pls_pkg.sv ====
// types shared by the logic slice files
package pls_pkg;
    typedef enum logic [1:0] {
        PLS_MODE_LOGIC,
        PLS_MODE_RIPPLE,
        PLS_MODE_RAM,
        PLS_MODE_ROM
    } pls_mode_e;
    typedef enum logic [2:0] {
        PLS_OP_ADD,
        PLS_OP_SUB,
        PLS_OP_UP,
        PLS_OP_DOWN,
        PLS_OP_CMP
    } pls_op_e;
endpackage : pls_pkg

// ==== src/pls_ripple.sv ====
// 2-bit arithmetic unit: add, subtract, compare, with carry generate/propagate
`timescale 1ns/1ps
`include "pls_defines.svh"
module pls_ripple
    import pls_pkg::*;
#(
    parameter int W = `PLS_COUNT_WIDTH
) (
    input  wire logic [W-1:0] a_i,
    input  wire logic [W-1:0] b_i,
    input  wire logic         cin_i,
    input  wire pls_op_e      op_i,
    output logic [W-1:0]      sum_o,
    output logic              cout_o,
    output logic              gen_o,
    output logic              prop_o,
    output logic              ge_o,
    output logic              ne_o,
    output logic              le_o
);
    logic [W-1:0] b_eff;
    logic [W:0]   full;
    logic [W:0]   g_c;

    always_comb begin
        unique case (op_i)
            PLS_OP_SUB:  b_eff = ~b_i;
            PLS_OP_UP:   b_eff = {W{1'b0}};
            PLS_OP_DOWN: b_eff = {W{1'b1}};
            default:     b_eff = b_i;
        endcase
        full   = {1'b0, a_i} + {1'b0, b_eff} + {{W{1'b0}}, cin_i};
        sum_o  = full[W-1:0];
        cout_o = full[W];
        g_c    = {1'b0, a_i} + {1'b0, b_eff};
        gen_o  = g_c[W];
        prop_o = &(a_i ^ b_eff);
        ge_o   = (a_i >= b_i);
        ne_o   = (a_i != b_i);
        le_o   = (a_i <= b_i);
    end
endmodule : pls_ripple

// ==== src/pls_slice.sv ====
// configurable logic slice: two four-input tables, ripple unit, RAM and ROM
`timescale 1ns/1ps
`include "pls_defines.svh"
module pls_slice
    import pls_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clk_en_i,
    input  wire logic        cfg_load_i,
    input  wire pls_mode_e   cfg_mode_i,
    input  wire logic        cfg_fast_carry_i,
    input  wire pls_op_e     cfg_op_i,
    input  wire logic [15:0] cfg_init0_i,
    input  wire logic [15:0] cfg_init1_i,
    input  wire logic [3:0]  lut_in0_i,
    input  wire logic [3:0]  lut_in1_i,
    input  wire logic        sel5_i,
    input  wire logic        casc_sel_i,
    input  wire logic        casc_in_i,
    input  wire logic [1:0]  a_i,
    input  wire logic [1:0]  b_i,
    input  wire logic        cin_i,
    input  wire logic        wr_en_i,
    input  wire logic [3:0]  wr_addr_i,
    input  wire logic [1:0]  wr_data_i,
    input  wire logic [3:0]  rd_addr_i,
    output logic [1:0]       f_o,
    output logic             f5_o,
    output logic             casc_o,
    output logic [1:0]       sum_o,
    output logic             cout_o,
    output logic             gen_o,
    output logic             prop_o,
    output logic             ge_o,
    output logic             ne_o,
    output logic             le_o,
    output logic [1:0]       count_o
);
    logic [1:0] tbl_q;
    logic [3:0] addr0;
    logic [3:0] addr1;
    logic [1:0] wr_en_t;
    logic [1:0] r_sum;
    logic       r_cout;
    logic       r_gen;
    logic       r_prop;
    logic       r_ge;
    logic       r_ne;
    logic       r_le;
    logic       f5;

    // registered outputs
    logic [1:0] f_r, f_nxt;
    logic       f5_r, f5_nxt, casc_r, casc_nxt;
    logic [1:0] sum_r, sum_nxt, count_r, count_nxt;
    logic       cout_r, cout_nxt, gen_r, gen_nxt, prop_r, prop_nxt;
    logic       ge_r, ge_nxt, ne_r, ne_nxt, le_r, le_nxt;

    // memory modes address by the read port; logic mode by table inputs
    always_comb begin
        if (cfg_mode_i == PLS_MODE_RAM || cfg_mode_i == PLS_MODE_ROM) begin
            addr0 = rd_addr_i;
            addr1 = rd_addr_i;
        end else begin
            addr0 = lut_in0_i;
            addr1 = lut_in1_i;
        end
    end

    // write enables reach the tables in RAM mode only, so stray enables in ROM do nothing
    assign wr_en_t = {2{wr_en_i && cfg_mode_i == PLS_MODE_RAM}};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tbl
            pls_table u_tbl (
                .sys_clk_i          (sys_clk_i),
                .rst_n_i            (rst_n_i),
                .clk_en_i           (clk_en_i),
                .cfg_load_i         (cfg_load_i),
                .cfg_init_i         (gi == 0 ? cfg_init0_i : cfg_init1_i),
                .wr_en_i            (wr_en_t[gi]),
                .wr_addr_i          (wr_addr_i),
                .wr_data_i          (wr_data_i[gi]),
                .rd_addr_i          (gi == 0 ? addr0 : addr1),
                .rd_data_o          (tbl_q[gi]),
                .rd_addr_alt_dummy_o()
            );
        end
    endgenerate

    assign f5 = sel5_i ? tbl_q[1] : tbl_q[0];

    pls_ripple u_rip (
        .a_i    (cfg_op_i == PLS_OP_UP || cfg_op_i == PLS_OP_DOWN ? count_r : a_i),
        .b_i    (b_i),
        .cin_i  (cfg_op_i == PLS_OP_UP ? 1'b1 : (cfg_op_i == PLS_OP_DOWN ? 1'b0 : cin_i)),
        .op_i   (cfg_op_i),
        .sum_o  (r_sum),
        .cout_o (r_cout),
        .gen_o  (r_gen),
        .prop_o (r_prop),
        .ge_o   (r_ge),
        .ne_o   (r_ne),
        .le_o   (r_le)
    );

    // outputs are registered; reads still see the addressed word next edge
    always_comb begin
        f_nxt     = 2'h0;
        f5_nxt    = 1'b0;
        casc_nxt  = 1'b0;
        sum_nxt   = 2'h0;
        cout_nxt  = 1'b0;
        gen_nxt   = 1'b0;
        prop_nxt  = 1'b0;
        ge_nxt    = 1'b0;
        ne_nxt    = 1'b0;
        le_nxt    = 1'b0;
        count_nxt = count_r;
        unique case (cfg_mode_i)
            PLS_MODE_LOGIC: begin
                f_nxt    = tbl_q;
                f5_nxt   = f5;
                casc_nxt = casc_sel_i ? casc_in_i : f5;
            end
            PLS_MODE_RIPPLE: begin
                sum_nxt  = r_sum;
                cout_nxt = r_cout;
                gen_nxt  = cfg_fast_carry_i & r_gen;
                prop_nxt = cfg_fast_carry_i & r_prop;
                ge_nxt   = r_ge;
                ne_nxt   = r_ne;
                le_nxt   = r_le;
                if (cfg_op_i == PLS_OP_UP || cfg_op_i == PLS_OP_DOWN) begin
                    count_nxt = r_sum;
                    sum_nxt   = r_sum;
                end
            end
            PLS_MODE_RAM, PLS_MODE_ROM: begin
                f_nxt = tbl_q;
            end
        endcase
        if (cfg_load_i) begin
            count_nxt = `PLS_COUNT_RESET;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            f_r     <= 2'h0;
            f5_r    <= 1'b0;
            casc_r  <= 1'b0;
            sum_r   <= 2'h0;
            cout_r  <= 1'b0;
            gen_r   <= 1'b0;
            prop_r  <= 1'b0;
            ge_r    <= 1'b0;
            ne_r    <= 1'b0;
            le_r    <= 1'b0;
            count_r <= `PLS_COUNT_RESET;
        end else if (clk_en_i) begin
            f_r     <= f_nxt;
            f5_r    <= f5_nxt;
            casc_r  <= casc_nxt;
            sum_r   <= sum_nxt;
            cout_r  <= cout_nxt;
            gen_r   <= gen_nxt;
            prop_r  <= prop_nxt;
            ge_r    <= ge_nxt;
            ne_r    <= ne_nxt;
            le_r    <= le_nxt;
            count_r <= count_nxt;
        end
    end

    assign f_o     = f_r;
    assign f5_o    = f5_r;
    assign casc_o  = casc_r;
    assign sum_o   = sum_r;
    assign cout_o  = cout_r;
    assign gen_o   = gen_r;
    assign prop_o  = prop_r;
    assign ge_o    = ge_r;
    assign ne_o    = ne_r;
    assign le_o    = le_r;
    assign count_o = count_r;

    property p_count_up;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !cfg_load_i && cfg_mode_i == PLS_MODE_RIPPLE && cfg_op_i == PLS_OP_UP)
        |=> count_r == 2'($past(count_r) + 2'h1);
    endproperty
    a_count_up: assert property (p_count_up) else $error("count did not step up");

    property p_count_down;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !cfg_load_i && cfg_mode_i == PLS_MODE_RIPPLE && cfg_op_i == PLS_OP_DOWN)
        |=> count_r == 2'($past(count_r) - 2'h1);
    endproperty
    a_count_down: assert property (p_count_down) else $error("count did not step down");

    property p_wrap_carry;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && cfg_mode_i == PLS_MODE_RIPPLE && cfg_op_i == PLS_OP_UP
         && count_r == 2'h3 && !cfg_load_i) |=> (count_r == 2'h0 && cout_r);
    endproperty
    a_wrap_carry: assert property (p_wrap_carry) else $error("no carry on wrap");

    property p_add;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && cfg_mode_i == PLS_MODE_RIPPLE && cfg_op_i == PLS_OP_ADD)
        |=> {cout_r, sum_r}
            == ({1'b0, $past(a_i)} + {1'b0, $past(b_i)} + {2'h0, $past(cin_i)});
    endproperty
    a_add: assert property (p_add) else $error("wrong sum");

    property p_cmp;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && cfg_mode_i == PLS_MODE_RIPPLE && cfg_op_i == PLS_OP_CMP)
        |=> (ge_r == ($past(a_i) >= $past(b_i)) && ne_r == ($past(a_i) != $past(b_i))
             && le_r == ($past(a_i) <= $past(b_i)));
    endproperty
    a_cmp: assert property (p_cmp) else $error("wrong compare");

    property p_no_carry_flags;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !cfg_fast_carry_i) |=> (!gen_r && !prop_r);
    endproperty
    a_no_carry_flags: assert property (p_no_carry_flags) else $error("carry flags leak");

    property p_ram_write_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && !cfg_load_i && cfg_mode_i == PLS_MODE_RAM && wr_en_i
         && wr_addr_i == rd_addr_i) ##1 (clk_en_i && cfg_mode_i == PLS_MODE_RAM
         && $stable(rd_addr_i)) |=> f_r == $past(wr_data_i, 2);
    endproperty
    a_ram_write_read: assert property (p_ram_write_read) else $error("write lost");

    property p_rom_const;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (cfg_mode_i == PLS_MODE_ROM && !cfg_load_i && clk_en_i)
        |=> $stable(g_tbl[0].u_tbl.mem_r) && $stable(g_tbl[1].u_tbl.mem_r);
    endproperty
    a_rom_const: assert property (p_rom_const) else $error("rom contents changed");

    property p_f5;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && cfg_mode_i == PLS_MODE_LOGIC)
        |=> f5_r == ($past(sel5_i) ? $past(tbl_q[1]) : $past(tbl_q[0]));
    endproperty
    a_f5: assert property (p_f5) else $error("five-input select wrong");

    property p_sub;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && cfg_mode_i == PLS_MODE_RIPPLE && cfg_op_i == PLS_OP_SUB)
        |=> {cout_r, sum_r}
            == ({1'b0, $past(a_i)} + {1'b0, ~$past(b_i)} + {2'h0, $past(cin_i)});
    endproperty
    a_sub: assert property (p_sub) else $error("wrong difference");

    // gen is the carry of a+b without carry-in, so chains need no ripple
    property p_gen_prop;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && cfg_fast_carry_i && cfg_mode_i == PLS_MODE_RIPPLE
         && cfg_op_i == PLS_OP_ADD)
        |=> (gen_r == (({1'b0, $past(a_i)} + {1'b0, $past(b_i)}) > 3'h3)
             && prop_r == &($past(a_i) ^ $past(b_i)));
    endproperty
    a_gen_prop: assert property (p_gen_prop) else $error("wrong generate or propagate");

    property p_casc;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && cfg_mode_i == PLS_MODE_LOGIC && casc_sel_i)
        |=> casc_r == $past(casc_in_i);
    endproperty
    a_casc: assert property (p_casc) else $error("cascade input not passed");

    property p_table_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && cfg_mode_i == PLS_MODE_LOGIC)
        |=> f_r == $past({g_tbl[1].u_tbl.mem_r[lut_in1_i], g_tbl[0].u_tbl.mem_r[lut_in0_i]});
    endproperty
    a_table_read: assert property (p_table_read) else $error("table output wrong");

    // a frozen slice keeps count and contents, whatever else toggles
    property p_freeze;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !clk_en_i |=> $stable(count_r) && $stable(g_tbl[0].u_tbl.mem_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");

    // unused outputs other than count_o sit at zero so a neighbour never sees stale results; count_o holds its value until a configuration load clears it
    property p_mem_idle;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        (clk_en_i && (cfg_mode_i == PLS_MODE_RAM || cfg_mode_i == PLS_MODE_ROM))
        |=> (sum_r == 2'h0 && !cout_r && !ge_r && !ne_r && !le_r && !f5_r);
    endproperty
    a_mem_idle: assert property (p_mem_idle) else $error("idle outputs not zero");
endmodule : pls_slice

// ==== src/pls_table.sv ====
// one sixteen-entry table: truth table in logic mode, 16x1 memory in RAM and ROM modes
`timescale 1ns/1ps
`include "pls_defines.svh"
module pls_table
    import pls_pkg::*;
#(
    parameter int ENTRIES = `PLS_TABLE_ENTRIES,
    parameter int AW      = `PLS_TABLE_INPUTS
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             clk_en_i,
    input  wire logic             cfg_load_i,
    input  wire logic [ENTRIES-1:0] cfg_init_i,
    input  wire logic             wr_en_i,
    input  wire logic [AW-1:0]    wr_addr_i,
    input  wire logic             wr_data_i,
    input  wire logic [AW-1:0]    rd_addr_i,
    output logic                  rd_data_o,
    output logic [AW-1:0]         rd_addr_alt_dummy_o
);
    logic [ENTRIES-1:0] mem_r;
    logic [ENTRIES-1:0] mem_nxt;

    // configuration load wins over a user write
    always_comb begin
        mem_nxt = mem_r;
        if (cfg_load_i) begin
            mem_nxt = cfg_init_i;
        end else if (wr_en_i) begin
            mem_nxt[wr_addr_i] = wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_r <= `PLS_TABLE_INIT;
        end else if (clk_en_i) begin
            mem_r <= mem_nxt;
        end
    end

    assign rd_data_o           = mem_r[rd_addr_i];
    assign rd_addr_alt_dummy_o = rd_addr_i;
endmodule : pls_table

// ==== verif/pls_nbr_model.sv ====
// neighbouring slice of the same cell group, feeding the cascade input
`timescale 1ns/1ps
module pls_nbr_model #(
    parameter logic [15:0] TABLE = 16'h6996
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [3:0] addr_i,
    output logic            f_o
);
    // registered like a real slice output, so a cascade costs one more cycle
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            f_o <= 1'b0;
        end else begin
            f_o <= TABLE[addr_i];
        end
    end
endmodule : pls_nbr_model

// ==== verif/programmable_logic_slice_tb.sv ====
// self-checking bench for the logic slice
`timescale 1ns/1ps
module programmable_logic_slice_tb
    import pls_pkg::*;
;
    localparam logic [15:0] T0 = 16'h8e3a;
    localparam logic [15:0] T1 = 16'h51c7;
    localparam logic [15:0] NT = 16'h6996;
    logic            sys_clk_i = 1'b0;
    logic            rst_n_i, clk_en_i, cfg_load_i, cfg_fast_carry_i;
    pls_mode_e       cfg_mode_i;
    pls_op_e         cfg_op_i;
    logic [15:0]     cfg_init0_i, cfg_init1_i;
    logic [3:0]      lut_in0_i, lut_in1_i, wr_addr_i, rd_addr_i;
    logic            sel5_i, casc_sel_i, casc_in_i, cin_i, wr_en_i;
    logic [1:0]      a_i, b_i, wr_data_i;
    logic [1:0]      f_o, sum_o, count_o;
    logic            f5_o, casc_o, cout_o, gen_o, prop_o, ge_o, ne_o, le_o;
    logic [3:0]      pair_rd_addr;
    logic [1:0]      pair_f;
    int              fail_count = 0;
    int              n_checks = 0;

    always #25 sys_clk_i = ~sys_clk_i;

    pls_nbr_model #(.TABLE(NT)) nbr (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .addr_i(lut_in0_i), .f_o(casc_in_i));

    pls_slice dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .cfg_load_i(cfg_load_i), .cfg_mode_i(cfg_mode_i), .cfg_fast_carry_i(cfg_fast_carry_i),
        .cfg_op_i(cfg_op_i), .cfg_init0_i(cfg_init0_i), .cfg_init1_i(cfg_init1_i),
        .lut_in0_i(lut_in0_i), .lut_in1_i(lut_in1_i), .sel5_i(sel5_i),
        .casc_sel_i(casc_sel_i), .casc_in_i(casc_in_i), .a_i(a_i), .b_i(b_i), .cin_i(cin_i),
        .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .rd_addr_i(rd_addr_i),
        .f_o(f_o), .f5_o(f5_o), .casc_o(casc_o), .sum_o(sum_o), .cout_o(cout_o),
        .gen_o(gen_o), .prop_o(prop_o), .ge_o(ge_o), .ne_o(ne_o), .le_o(le_o),
        .count_o(count_o));

    // companion slice: shares the write side, reads on its own address
    pls_slice u_pair (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .cfg_load_i(cfg_load_i), .cfg_mode_i(cfg_mode_i), .cfg_fast_carry_i(cfg_fast_carry_i),
        .cfg_op_i(cfg_op_i), .cfg_init0_i(cfg_init0_i), .cfg_init1_i(cfg_init1_i),
        .lut_in0_i(lut_in0_i), .lut_in1_i(lut_in1_i), .sel5_i(sel5_i),
        .casc_sel_i(casc_sel_i), .casc_in_i(casc_in_i), .a_i(a_i), .b_i(b_i), .cin_i(cin_i),
        .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i),
        .rd_addr_i(pair_rd_addr), .f_o(pair_f), .f5_o(), .casc_o(), .sum_o(), .cout_o(),
        .gen_o(), .prop_o(), .ge_o(), .ne_o(), .le_o(), .count_o());

    task automatic give_verdict;
        if (fail_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : step

    // one enabled edge with load high; also clears the count
    task automatic load(input pls_mode_e m, input logic [15:0] i0, input logic [15:0] i1);
        cfg_mode_i = m;
        cfg_init0_i = i0;
        cfg_init1_i = i1;
        cfg_load_i = 1'b1;
        step(1);
        cfg_load_i = 1'b0;
    endtask : load

    task automatic t_logic;
        load(PLS_MODE_LOGIC, T0, T1);
        for (int a = 0; a < 16; a++) begin
            lut_in0_i = 4'(a);
            lut_in1_i = 4'(a);
            sel5_i = a[0];
            casc_sel_i = a[1];
            step(2);
            chk(8'(f_o), 8'({T1[a], T0[a]}));
            chk(8'(f5_o), 8'(a[0] ? T1[a] : T0[a]));
            chk(8'(casc_o), 8'(a[1] ? NT[a] : (a[0] ? T1[a] : T0[a])));
        end
    endtask : t_logic

    task automatic t_arith(input pls_op_e op);
        logic [1:0] bx;
        logic [2:0] s;
        cfg_mode_i = PLS_MODE_RIPPLE;
        cfg_op_i = op;
        cfg_fast_carry_i = 1'b1;
        for (int v = 0; v < 32; v++) begin
            a_i = v[1:0];
            b_i = v[3:2];
            cin_i = v[4];
            step(1);
            bx = (op == PLS_OP_SUB) ? ~b_i : b_i;
            s = {1'b0, a_i} + {1'b0, bx} + {2'b0, cin_i};
            chk(8'({sum_o, cout_o}), 8'({s[1:0], s[2]}));
            s = {1'b0, a_i} + {1'b0, bx};
            chk(8'({gen_o, prop_o}), 8'({s[2], &(a_i ^ bx)}));
        end
        cfg_fast_carry_i = 1'b0;
        step(1);
        chk(8'({gen_o, prop_o}), 8'h00);
    endtask : t_arith

    task automatic t_cmp;
        cfg_op_i = PLS_OP_CMP;
        for (int v = 0; v < 16; v++) begin
            a_i = v[1:0];
            b_i = v[3:2];
            step(1);
            chk(8'({ge_o, ne_o, le_o}), 8'({v[1:0] >= v[3:2], v[1:0] != v[3:2],
                v[1:0] <= v[3:2]}));
        end
    endtask : t_cmp

    task automatic t_count;
        logic [1:0] c;
        load(PLS_MODE_RIPPLE, 16'h0000, 16'h0000);
        cfg_op_i = PLS_OP_UP;
        c = 2'h0;
        for (int i = 0; i < 6; i++) begin
            step(1);
            c = c + 2'h1;
            chk(8'({count_o, sum_o, cout_o}), 8'({c, c, c == 2'h0}));
        end
        clk_en_i = 1'b0; // frozen count must hold
        step(3);
        chk(8'(count_o), 8'(c));
        clk_en_i = 1'b1;
        cfg_op_i = PLS_OP_DOWN;
        for (int i = 0; i < 6; i++) begin
            step(1);
            c = c - 2'h1;
            chk(8'({count_o, cout_o}), 8'({c, c != 2'h3}));
        end
    endtask : t_count

    task automatic t_mem;
        load(PLS_MODE_RAM, 16'h0000, 16'hffff);
        wr_en_i = 1'b1;
        for (int a = 0; a < 16; a++) begin
            wr_addr_i = 4'(a);
            wr_data_i = 2'(a) ^ 2'h1;
            step(1);
        end
        wr_en_i = 1'b0;
        for (int a = 0; a < 16; a++) begin
            rd_addr_i = 4'(a);
            pair_rd_addr = 4'(15 - a);
            step(1);
            chk(8'(f_o), 8'(2'(a) ^ 2'h1));
            chk(8'(pair_f), 8'(2'(15 - a) ^ 2'h1));
        end
        // rom keeps its loaded image against every write attempt
        load(PLS_MODE_ROM, T0, T1);
        wr_en_i = 1'b1;
        for (int a = 0; a < 16; a++) begin
            wr_addr_i = 4'(a);
            rd_addr_i = 4'(a);
            wr_data_i = ~{T1[a], T0[a]};
            step(2);
            chk(8'(f_o), 8'({T1[a], T0[a]}));
        end
        wr_en_i = 1'b0;
    endtask : t_mem

    initial begin
        {rst_n_i, cfg_load_i, cfg_fast_carry_i, sel5_i, casc_sel_i, cin_i, wr_en_i} = '0;
        {cfg_init0_i, cfg_init1_i, lut_in0_i, lut_in1_i, wr_addr_i, rd_addr_i} = '0;
        {a_i, b_i, wr_data_i} = '0;
        pair_rd_addr = 4'h0;
        clk_en_i = 1'b1;
        cfg_mode_i = PLS_MODE_LOGIC;
        cfg_op_i = PLS_OP_ADD;
        step(16);
        rst_n_i = 1'b1;
        chk(8'({f_o, sum_o, count_o, cout_o, f5_o}), 8'h00);
        t_logic();
        t_arith(PLS_OP_ADD);
        t_arith(PLS_OP_SUB);
        t_cmp();
        t_count();
        t_mem();
        give_verdict();
    end

    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        give_verdict();
    end
endmodule : programmable_logic_slice_tb
